/* hdl/swhp_pkg.sv */
// Purpose: Shared constants for the single-wire host port
// Assumes: 10 MHz system clock
// Notes:   Slot times are plain defaults; adjust to the host in use
package swhp_pkg;

  localparam int SYS_CLK_MHZ = 10;

  // Times in microseconds
  localparam int BREAK_MIN_US      = 190;
  localparam int BIT_THRESH_US     = 68;
  localparam int TURNAROUND_US     = 100;
  localparam int DEV_ZERO_LOW_US   = 100;
  localparam int DEV_ONE_LOW_US    = 40;
  localparam int DEV_SLOT_US       = 200;

  localparam int CNT_W = 12;

  localparam logic [CNT_W-1:0] BREAK_CYC    = CNT_W'(BREAK_MIN_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] THRESH_CYC   = CNT_W'(BIT_THRESH_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] TURN_CYC     = CNT_W'(TURNAROUND_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] DEV_ZERO_CYC = CNT_W'(DEV_ZERO_LOW_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] DEV_ONE_CYC  = CNT_W'(DEV_ONE_LOW_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] DEV_SLOT_CYC = CNT_W'(DEV_SLOT_US * SYS_CLK_MHZ);
  localparam logic [CNT_W-1:0] CNT_MAX      = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE      = CNT_W'(1);

  localparam int BYTE_W   = 8;
  localparam int CODE_W   = 7;
  localparam int DIR_BIT  = 7;
  localparam int ENTRY_W  = CODE_W + BYTE_W;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ONE  = 3'h1;

  typedef enum logic [2:0] {
    SWHP_IDLE,
    SWHP_BRK,
    SWHP_CMD,
    SWHP_WDATA,
    SWHP_PUSH,
    SWHP_RWAIT,
    SWHP_TURN,
    SWHP_TX
  } swhp_state_t;

endpackage : swhp_pkg

/* hdl/swhp_buf.sv */
// Purpose: Two-entry buffer between the link and the user side
// Assumes: Single clock, synchronous active-high reset
// Notes:   Output word and valid come straight from flip-flops
`timescale 1ns/100ps
`default_nettype none
module swhp_buf
  import swhp_pkg::*;
(
  input  wire logic               sys_clk_i,   // System clock
  input  wire logic               rst_i,       // Sync reset
  input  wire logic               in_valid_i,  // Word offered
  output logic                    in_ready_o,  // Room for a word
  input  wire logic [ENTRY_W-1:0] in_data_i,   // Word in
  output logic                    out_valid_o, // Word available
  input  wire logic               out_ready_i, // Consumer takes word
  output logic [ENTRY_W-1:0]      out_data_o   // Word out
);

  typedef struct packed {
    logic [ENTRY_W-1:0] d0;
    logic [ENTRY_W-1:0] d1;
    logic               v0;
    logic               v1;
  } swhp_buf_t;

  swhp_buf_t buf_r;
  swhp_buf_t buf_nxt;

  assign in_ready_o  = ~buf_r.v1;
  assign out_valid_o = buf_r.v0;
  assign out_data_o  = buf_r.d0;

  always_comb
  begin
    buf_nxt = buf_r;
    if (buf_r.v0 && out_ready_i)
    begin
      buf_nxt.d0 = buf_r.d1;
      buf_nxt.v0 = buf_r.v1;
      buf_nxt.v1 = 1'b0;
    end
    if (in_valid_i && !buf_r.v1)
    begin
      if (!buf_nxt.v0)
      begin
        buf_nxt.d0 = in_data_i;
        buf_nxt.v0 = 1'b1;
      end
      else
      begin
        buf_nxt.d1 = in_data_i;
        buf_nxt.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      buf_r <= '0;
    else
      buf_r <= buf_nxt;
  end

endmodule : swhp_buf
`default_nettype wire

/* hdl/swhp_top.sv */
// Purpose: Device-side single-wire return-to-one host port
// Assumes: 10 MHz clock; external pull-up on the data wire
// Notes:   Write bytes leave through a two-entry buffer; reads ask the user side
// Behaviour
// - Command and data travel LSB first
// - Command: 7-bit code, bit 7 direction
// - Direction selects receive or return data byte
// - Port only answers, never starts transactions
// - Open-drain: pull low or release only
// - Device returns read byte as eight slots
// - One byte per transaction, no increment
// - Enter link mode from setting or subcommand
// - Apply subcommand switches to stored selection; a switch subcommand in the same cycle overrides it
// - Switch subcommand selects link on alert pin
// - Traffic on alert or dedicated pin
`timescale 1ns/100ps
`default_nettype none
module swhp_top
  import swhp_pkg::*;
(
  input  wire logic                     sys_clk_i,          // System clock
  input  wire logic                     rst_i,              // Sync reset
  input  wire logic                     cfg_single_wire_i,  // Stored setting: link mode
  input  wire logic                     cfg_use_ded_i,      // Stored setting: dedicated pin
  input  wire logic                     apply_sel_i,        // Apply-selection pulse
  input  wire logic                     switch_sw_i,        // Switch-to-link pulse
  input  wire logic                     alert_i,            // Alert pin level
  output logic                          alert_o,            // Alert pin out (always low)
  output logic                          alert_oe_o,         // Alert pin pull-low enable
  input  wire logic                     wire_i,             // Dedicated pin level
  output logic                          wire_o,             // Dedicated pin out (low)
  output logic                          wire_oe_o,          // Dedicated pin pull-low enable
  output logic                          link_active_o,      // Link mode active
  output logic                          use_ded_o,          // Dedicated pin in use
  output logic                          wr_valid_o,         // Write word available
  input  wire logic                     wr_ready_i,         // User takes write word
  output logic [swhp_pkg::CODE_W-1:0]   wr_code_o,          // Written command code
  output logic [swhp_pkg::BYTE_W-1:0]   wr_data_o,          // Written data byte
  output logic                          rd_req_o,           // Read request pulse
  output logic [swhp_pkg::CODE_W-1:0]   rd_code_o,          // Read command code
  input  wire logic                     rd_valid_i,         // Read data offered
  input  wire logic [swhp_pkg::BYTE_W-1:0] rd_data_i        // Read data byte
);

  typedef struct packed {
    swhp_state_t        st;
    logic               s1;
    logic               s2;
    logic               s3;
    logic               line;
    logic [CNT_W-1:0]   lowcnt;
    logic [CNT_W-1:0]   cnt;
    logic [2:0]         nbit;
    logic [BYTE_W-1:0]  sh;
    logic [BYTE_W-1:0]  cmd;
    logic [BYTE_W-1:0]  txd;
    logic               drive;
    logic               init;
    logic               link_on;
    logic               use_ded;
    logic               alert_oe;
    logic               wire_oe;
    logic               pin_lvl;
    logic               rd_req;
  } swhp_core_t;

  swhp_core_t q_r;
  swhp_core_t q_nxt;

  logic               push_valid;
  logic               push_ready;
  logic [ENTRY_W-1:0] push_data;
  logic [ENTRY_W-1:0] pop_data;

  function automatic logic swhp_bit_of(input logic [CNT_W-1:0] low);
    swhp_bit_of = (low < THRESH_CYC);
  endfunction : swhp_bit_of

  assign push_valid = (q_r.st == SWHP_PUSH);
  assign push_data  = {q_r.cmd[CODE_W-1:0], q_r.sh};

  swhp_buf u_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (pop_data)
  );

  assign wr_code_o     = pop_data[ENTRY_W-1:BYTE_W];
  assign wr_data_o     = pop_data[BYTE_W-1:0];
  assign alert_o       = q_r.pin_lvl;
  assign wire_o        = q_r.pin_lvl;
  assign alert_oe_o    = q_r.alert_oe;
  assign wire_oe_o     = q_r.wire_oe;
  assign link_active_o = q_r.link_on;
  assign use_ded_o     = q_r.use_ded;
  assign rd_req_o      = q_r.rd_req;
  assign rd_code_o     = q_r.cmd[CODE_W-1:0];

  always_comb
  begin
    logic             rise;
    logic             fall;
    logic             bitv;
    logic [BYTE_W-1:0] nsh;
    logic [CNT_W-1:0] lowlim;
    rise = 1'b0;
    fall = 1'b0;
    bitv = 1'b0;
    nsh  = '0;
    lowlim = '0;
    q_nxt = q_r;
    q_nxt.rd_req = 1'b0;
    // Three-stage sampler on the selected pin
    q_nxt.s1 = q_r.use_ded ? wire_i : alert_i;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    if (q_r.s2 == q_r.s3)
      q_nxt.line = q_r.s3;
    rise = ~q_r.line & q_nxt.line;
    fall = q_r.line & ~q_nxt.line;
    if (fall)
      q_nxt.lowcnt = '0;
    else if (!q_r.line && q_r.lowcnt != CNT_MAX)
      q_nxt.lowcnt = q_r.lowcnt + CNT_ONE;
    bitv = swhp_bit_of(q_r.lowcnt);
    nsh  = {bitv, q_r.sh[BYTE_W-1:1]};

    case (q_r.st)
      SWHP_IDLE:
        q_nxt.drive = 1'b0;
      SWHP_BRK:
        if (rise)
        begin
          q_nxt.st   = SWHP_CMD;
          q_nxt.nbit = '0;
        end
      SWHP_CMD:
        if (rise)
        begin
          q_nxt.sh   = nsh;
          q_nxt.nbit = q_r.nbit + BIT_ONE;
          if (q_r.nbit == LAST_BIT)
          begin
            q_nxt.cmd  = nsh;
            q_nxt.nbit = '0;
            if (nsh[DIR_BIT])
              q_nxt.st = SWHP_WDATA;
            else
            begin
              q_nxt.st     = SWHP_RWAIT;
              q_nxt.rd_req = 1'b1;
            end
          end
        end
      SWHP_WDATA:
        if (rise)
        begin
          q_nxt.sh   = nsh;
          q_nxt.nbit = q_r.nbit + BIT_ONE;
          if (q_r.nbit == LAST_BIT)
            q_nxt.st = SWHP_PUSH;
        end
      SWHP_PUSH:
        if (push_ready)
          q_nxt.st = SWHP_IDLE;
      SWHP_RWAIT:
        if (rd_valid_i)
        begin
          q_nxt.txd = rd_data_i;
          q_nxt.cnt = '0;
          q_nxt.st  = SWHP_TURN;
        end
      SWHP_TURN:
        if (q_r.cnt >= TURN_CYC)
        begin
          q_nxt.cnt   = '0;
          q_nxt.nbit  = '0;
          q_nxt.drive = 1'b1;
          q_nxt.st    = SWHP_TX;
        end
        else
          q_nxt.cnt = q_r.cnt + CNT_ONE;
      SWHP_TX:
      begin
        q_nxt.cnt = q_r.cnt + CNT_ONE;
        lowlim = q_r.txd[0] ? DEV_ONE_CYC : DEV_ZERO_CYC;
        if (q_r.cnt >= lowlim - CNT_ONE)
          q_nxt.drive = 1'b0;
        if (q_r.cnt >= DEV_SLOT_CYC - CNT_ONE)
        begin
          q_nxt.cnt  = '0;
          q_nxt.txd  = {1'b0, q_r.txd[BYTE_W-1:1]};
          q_nxt.nbit = q_r.nbit + BIT_ONE;
          if (q_r.nbit == LAST_BIT)
            q_nxt.st = SWHP_IDLE;
          else
            q_nxt.drive = 1'b1;
        end
      end
      default:
        q_nxt.st = SWHP_IDLE;
    endcase

    // A long low from the host restarts the frame, except while we drive
    // or hold a word for the buffer; the break's own rise must reach BRK
    if (q_r.st != SWHP_TX && q_r.st != SWHP_PUSH && !q_r.line && !rise
        && q_r.lowcnt >= BREAK_CYC)
    begin
      q_nxt.st    = SWHP_BRK;
      q_nxt.drive = 1'b0;
    end

    // Mode selection
    if (!q_r.init || apply_sel_i)
    begin
      q_nxt.init    = 1'b1;
      q_nxt.link_on = cfg_single_wire_i;
      q_nxt.use_ded = cfg_use_ded_i;
    end
    if (switch_sw_i)
    begin
      q_nxt.link_on = 1'b1;
      q_nxt.use_ded = 1'b0;
    end
    if (q_nxt.link_on != q_r.link_on || q_nxt.use_ded != q_r.use_ded || !q_nxt.link_on)
    begin
      q_nxt.st    = SWHP_IDLE;
      q_nxt.drive = 1'b0;
    end

    q_nxt.pin_lvl  = 1'b0;
    q_nxt.alert_oe = q_nxt.drive & q_nxt.link_on & ~q_nxt.use_ded;
    q_nxt.wire_oe  = q_nxt.drive & q_nxt.link_on & q_nxt.use_ded;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q_r      <= '0;
      q_r.st   <= SWHP_IDLE;
      q_r.s1   <= 1'b1;
      q_r.s2   <= 1'b1;
      q_r.s3   <= 1'b1;
      q_r.line <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

endmodule : swhp_top
`default_nettype wire

/* tb/swhp_top_assertions.sv */
// Purpose: Checker for the single-wire host port
// Assumes: One clock, sync reset
// Notes:   Device low time counted in helper logic
`timescale 1ns/100ps
`default_nettype none
module swhp_chk
  import swhp_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cfg_single_wire_i, // Mode setting
  input wire logic cfg_use_ded_i, // Pin setting
  input wire logic apply_sel_i, // Apply
  input wire logic switch_sw_i, // Switch
  input wire logic alert_o, // Alert out
  input wire logic alert_oe_o, // Alert enable
  input wire logic wire_o, // Pin out
  input wire logic wire_oe_o, // Pin enable
  input wire logic link_active_o, // Link on
  input wire logic use_ded_o, // Pin in use
  input wire logic wr_valid_o, // Word waiting
  input wire logic wr_ready_i, // Word taken
  input wire logic [swhp_pkg::CODE_W-1:0] wr_code_o, // Code
  input wire logic [swhp_pkg::BYTE_W-1:0] wr_data_o, // Data
  input wire logic rd_req_o // Read request
);
  import swhp_pkg::*;
  logic [CNT_W-1:0] low_r, low_nxt;
  wire logic oe = alert_oe_o || wire_oe_o;
  always_comb low_nxt = oe ? low_r + CNT_ONE : '0;
  always_ff @(posedge sys_clk_i) low_r <= rst_i ? '0 : low_nxt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $past(rst_i) |-> !oe && !wr_valid_o && !rd_req_o; endproperty
  property p_low; !alert_o && !wire_o; endproperty
  property p_pin; !(alert_oe_o && use_ded_o) && !(wire_oe_o && !use_ded_o); endproperty
  property p_pulse; rd_req_o |=> !rd_req_o; endproperty
  property p_switch; switch_sw_i |=> link_active_o && !use_ded_o; endproperty
  property p_apply; apply_sel_i && !switch_sw_i |=> link_active_o == $past(cfg_single_wire_i)
    && use_ded_o == $past(cfg_use_ded_i); endproperty
  property p_hold; wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_code_o)
    && $stable(wr_data_o); endproperty
  property p_slot; $fell(oe) |-> low_r == DEV_ONE_CYC || low_r == DEV_ZERO_CYC; endproperty
  a_rst: assert property (p_rst) else $error("port active after reset");
  a_low: assert property (p_low) else $error("pin driven high");
  a_pin: assert property (p_pin) else $error("unselected pin driven");
  a_pulse: assert property (p_pulse) else $error("read request too long");
  a_switch: assert property (p_switch) else $error("switch ignored");
  a_apply: assert property (p_apply) else $error("selection not applied");
  a_hold: assert property (p_hold) else $error("word lost in stall");
  a_slot: assert property (p_slot) else $error("bad device low time");
  c_wr: cover property (wr_valid_o && wr_ready_i);
  c_rd: cover property (rd_req_o);
  c_slot: cover property ($fell(oe));
endmodule : swhp_chk
bind swhp_top swhp_chk chk_u (.sys_clk_i, .rst_i, .cfg_single_wire_i, .cfg_use_ded_i,
  .apply_sel_i, .switch_sw_i, .alert_o, .alert_oe_o, .wire_o, .wire_oe_o, .link_active_o,
  .use_ded_o, .wr_valid_o, .wr_ready_i, .wr_code_o, .wr_data_o, .rd_req_o);
`default_nettype wire

/* tb/swhp_host_model.sv */
// Purpose: Host that masters the single-wire link
// Assumes: Pull-up on the wire
// Notes:   One is 20 us low, zero 80 us, slot 100 us
`timescale 1ns/100ps
`default_nettype none
module swhp_host_model (
  input wire logic sys_clk_i, // Clock
  input wire logic line_i, // Wire level
  output var logic oe_o // Host pulls low
);
  initial oe_o = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #10;
  endtask : tick
  task automatic slot(input logic b);
    oe_o = 1'b1;
    tick(b ? 200 : 800);
    oe_o = 1'b0;
    tick(b ? 800 : 200);
  endtask : slot
  task automatic send_frame(input logic [7:0] cmd, input logic [7:0] dat, input logic wr);
    oe_o = 1'b1;
    tick(2000);
    oe_o = 1'b0;
    tick(200);
    for (int i = 0; i < 8; i++) slot(cmd[i]);
    if (wr) for (int i = 0; i < 8; i++) slot(dat[i]);
  endtask : send_frame
  task automatic recv_byte(output logic [7:0] d);
    int n;
    int m;
    d = 8'hXX;
    for (int i = 0; i < 8; i++)
    begin
      for (n = 0; n < 5000 && line_i !== 1'b0; n++) tick(1);
      for (m = 0; m < 5000 && line_i === 1'b0; m++) tick(1);
      // A wire that never goes low or never comes back leaves the bit unknown
      if (m > 0 && m < 5000) d[i] = (m < 700);
    end
  endtask : recv_byte
endmodule : swhp_host_model
`default_nettype wire

/* tb/swhp_top_tb_top.sv */
// Purpose: Self-checking bench for the single-wire host port
// Assumes: Host model on the far side
// Notes:   Buffered writes, a read, dedicated pin
`timescale 1ns/100ps
`default_nettype none
module swhp_top_tb_top;
  import swhp_pkg::*;
  logic sys_clk_i, rst_i = 1'b1, cfg_sw = 1'b0, cfg_ded = 1'b0, apply = 1'b0;
  logic sw_cmd = 1'b0, wr_ready = 1'b0, rd_valid = 1'b0, host_ded = 1'b0, host_oe;
  logic alert_o, alert_oe, wire_o, wire_oe, link, use_ded, wr_valid, rd_req;
  logic [CODE_W-1:0] wr_code, rd_code;
  logic [BYTE_W-1:0] wr_data, rd_data = 8'h00, got;
  int bad_count = 0, n_checks = 0;
  wire logic alert_lvl = !((host_oe && !host_ded) || alert_oe);
  wire logic wire_lvl = !((host_oe && host_ded) || wire_oe);
  swhp_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_single_wire_i(cfg_sw),
    .cfg_use_ded_i(cfg_ded), .apply_sel_i(apply), .switch_sw_i(sw_cmd), .alert_i(alert_lvl),
    .alert_o(alert_o), .alert_oe_o(alert_oe), .wire_i(wire_lvl), .wire_o(wire_o),
    .wire_oe_o(wire_oe), .link_active_o(link), .use_ded_o(use_ded), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_code_o(wr_code), .wr_data_o(wr_data), .rd_req_o(rd_req),
    .rd_code_o(rd_code), .rd_valid_i(rd_valid), .rd_data_i(rd_data));
  swhp_host_model host_u (.sys_clk_i(sys_clk_i), .line_i(host_ded ? wire_lvl : alert_lvl),
    .oe_o(host_oe));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #10;
  endtask : tick
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [14:0] g, input logic [14:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value t=%0t got %0h exp %0h", $time, g, e);
      bad_count++;
    end
  endtask : check
  task automatic wait_for(input logic rd);
    int i;
    for (i = 0; i < 20000 && (rd ? rd_req : wr_valid) !== 1'b1; i++) tick(1);
    if (i == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_for
  task automatic cfg_apply(input logic sw, input logic ded);
    cfg_sw = sw;
    cfg_ded = ded;
    apply = 1'b1;
    tick(1);
    apply = 1'b0;
  endtask : cfg_apply
  task automatic t_write_buffer;
    cfg_apply(1'b1, 1'b0);
    check(15'({link, use_ded}), 15'h2);
    host_u.send_frame(8'hAA, 8'hC5, 1'b1);
    host_u.send_frame(8'h93, 8'h3A, 1'b1);
    wait_for(1'b0);
    check({wr_code, wr_data}, {7'h2A, 8'hC5});
    wr_ready = 1'b1;
    tick(1);
    check({wr_code, wr_data}, {7'h13, 8'h3A});
    tick(1);
    wr_ready = 1'b0;
    check(15'(wr_valid), 15'h0);
  endtask : t_write_buffer
  task automatic t_read;
    sw_cmd = 1'b1;
    tick(1);
    sw_cmd = 1'b0;
    check(15'({link, use_ded}), 15'h2);
    fork
      begin
        host_u.send_frame(8'h15, 8'h00, 1'b0);
        host_u.recv_byte(got);
      end
      begin
        wait_for(1'b1);
        check(15'(rd_code), 15'h15);
        rd_data = 8'h9C;
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
      end
    join
    check(15'(got), 15'h9C);
  endtask : t_read
  task automatic t_ded;
    cfg_apply(1'b1, 1'b1);
    check(15'({link, use_ded}), 15'h3);
    host_ded = 1'b1;
    host_u.send_frame(8'hFF, 8'h00, 1'b1);
    wait_for(1'b0);
    check({wr_code, wr_data}, {7'h7F, 8'h00});
    wr_ready = 1'b1;
    tick(1);
    wr_ready = 1'b0;
  endtask : t_ded
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    #10;
    rst_i = 1'b0;
    tick(6);
    check(15'({link, wr_valid, rd_req, alert_oe, wire_oe}), 15'h0);
    t_write_buffer();
    t_read();
    t_ded();
    report_and_stop();
  end
endmodule : swhp_top_tb_top
`default_nettype wire
